// ### src/fsr_pkg.sv
// How it works
// - opcode 05h shifts out the volatile status byte
// - 01h writes, 65h reads, 71h writes this register by address
// - opcode 06h sets the write enable latch
// - opcode 04h clears the write enable latch
// - 30h or 82h clears both failure flags
// - bit 7 mirrors the stored write lock bit
// - bit 6 sets on program failure or protected program attempt
// - bit 5 sets on erase failure or protected sector erase attempt
// - bulk erase never sets the erase failure flag for protection
// - failure flags clear only by clear status or reset, never by writes
// - select 0: writes go to stored bits, copy shows in bits 4..2
// - select 1: writes change only bits 4..2, stored bits untouched
// - nonzero active protection refuses program and erase there
// - bulk erase runs only when all active protection bits are 0
// - latch clear: program, erase and register writes are ignored
// - latch clears when an operation completes successfully
// - latch is 0 after power up, hardware and software reset
// - only 06h sets the latch, write data never touches it
// - while busy only reads, suspends, clear status, reset act
// - suspends accepted only while the matching operation runs
// - flags update while busy; a set flag holds busy until cleared
// - lock bit 1 and protect pin low ignore register writes
package fsr_pkg;
  // ****************
  // opcodes
  // ****************
  localparam logic [7:0] READ_STATUS_ONE_CMD = 8'h05;
  localparam logic [7:0] WRITE_REGISTERS_CMD = 8'h01;
  localparam logic [7:0] READ_ANY_REGISTER_CMD = 8'h65;
  localparam logic [7:0] WRITE_ANY_REGISTER_CMD = 8'h71;
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] CLEAR_STATUS_CMD = 8'h30;
  localparam logic [7:0] CLEAR_STATUS_ALT_CMD = 8'h82;
  localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
  localparam logic [7:0] OTP_PROGRAM_CMD = 8'h42;
  localparam logic [7:0] SECTOR_ERASE_CMD = 8'hd8;
  localparam logic [7:0] BULK_ERASE_CMD = 8'h60;
  localparam logic [7:0] ERASE_SUSPEND_CMD = 8'h75;
  localparam logic [7:0] PROGRAM_SUSPEND_CMD = 8'h85;
  localparam logic [7:0] SOFT_RESET_CMD = 8'hf0;
  // ****************
  // register addresses
  // ****************
  localparam logic [23:0] STATUS_ONE_VOLATILE_ADDR = 24'h80_0000;
  localparam logic [23:0] STATUS_ONE_NONVOLATILE_ADDR = 24'h00_0000;
  // ****************
  // field positions
  // ****************
  localparam int LOCK_BIT = 7;
  localparam int PERR_BIT = 6;
  localparam int EERR_BIT = 5;
  localparam int PROT_TOP = 4;
  localparam int PROT_BOT = 2;
  localparam int LATCH_BIT = 1;
  localparam int BUSY_BIT = 0;
  // ****************
  // frame bit counts
  // ****************
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] WRITE_REG_BITS = 6'h10;
  localparam logic [5:0] ADDR_END_BITS = 6'h20;
  localparam logic [5:0] WRITE_ANY_BITS = 6'h28;
  localparam logic [5:0] COUNT_WRAP_FROM = 6'h2f;
  localparam logic [5:0] COUNT_WRAP_TO = 6'h28;
  // ****************
  // reset values
  // ****************
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [5:0] COUNT_RESET = 6'h00;
  // ****************
  // types
  // ****************
  typedef enum logic [1:0] {
    FSR_KIND_PROG,
    FSR_KIND_SERASE,
    FSR_KIND_BERASE,
    FSR_KIND_NVWR
  } fsr_kind_t;
  typedef enum logic {
    FSR_ENG_IDLE,
    FSR_ENG_RUN
  } fsr_eng_t;
endpackage

// ### src/fsr_sync.sv
`timescale 1ns/1ps
// three stage synchroniser; output moves once stages two and three agree
module fsr_sync #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // data
  input wire logic d_i,
  output logic q_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      q_o <= INIT;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_o <= s3_r;
      end
    end
  end
endmodule

// ### src/fsr_shout.sv
`timescale 1ns/1ps
// byte serialiser on the falling link clock, msb first
module fsr_shout (
  // link clock and frame clear
  input wire logic clk_i,
  input wire logic clear_i,
  // byte to send
  input wire logic load_i,
  input wire logic [7:0] byte_i,
  // serial out
  output logic bit_o
);
  logic [6:0] rest_r;

  // falling edge so the host samples a settled bit on the rising edge
  always_ff @(negedge clk_i or posedge clear_i) begin
    if (clear_i) begin
      bit_o <= 1'b0;
      rest_r <= 7'h00;
    end else if (load_i) begin
      bit_o <= byte_i[7];
      rest_r <= byte_i[6:0];
    end else begin
      bit_o <= rest_r[6];
      rest_r <= {rest_r[5:0], 1'b0};
    end
  end
endmodule

// ### src/fsr_status_one.sv
`timescale 1ns/1ps
module fsr_status_one
  import fsr_pkg::*;
(
  // system
  input wire logic clock_i,
  input wire logic reset_i,
  // spi link
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // pins
  input wire logic wp_n_i,
  // stored register and configuration
  input wire logic [7:0] nv_status_i,
  input wire logic prot_volatile_sel_i,
  // array engine requests
  output logic op_start_o,
  output fsr_kind_t op_kind_o,
  output logic [23:0] op_addr_o,
  output logic [7:0] nv_wdata_o,
  output logic op_suspend_o,
  output logic soft_reset_o,
  // array engine results
  input wire logic op_done_i,
  input wire logic prog_fail_i,
  input wire logic erase_fail_i,
  input wire logic op_suspended_i,
  input wire logic protect_hit_i,
  // status view
  output logic [7:0] status_o,
  output logic [2:0] active_prot_o
);

  // ****************
  // link side capture
  // ****************
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [5:0] len_r;
  logic [7:0] op_r;
  logic [23:0] addr_r;
  logic [7:0] byte1_r;
  logic [7:0] byte4_r;
  logic [7:0] spi_stat_r;
  logic [7:0] w1_r;
  logic [7:0] w2_r;
  logic [7:0] w3_r;
  logic rd_active;
  logic rd_load;
  logic [7:0] rd_byte;

  // count wraps inside the last byte so status polling never ends
  always_comb begin
    if (cnt_r == COUNT_WRAP_FROM) begin
      cnt_nxt = COUNT_WRAP_TO;
    end else begin
      cnt_nxt = cnt_r + 6'h01;
    end
  end

  // the frame signal clears the count; no clock edge outside frames
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      cnt_r <= COUNT_RESET;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // data stays put after the frame so the core can read it
  always_ff @(posedge sck_i) begin
    len_r <= cnt_nxt;
  end

  always_ff @(posedge sck_i) begin
    if (cnt_r < OPCODE_BITS) begin
      op_r <= {op_r[6:0], si_i};
    end
  end

  always_ff @(posedge sck_i) begin
    if (cnt_r >= OPCODE_BITS && cnt_r < ADDR_END_BITS) begin
      addr_r <= {addr_r[22:0], si_i};
    end
  end

  always_ff @(posedge sck_i) begin
    if (cnt_r >= OPCODE_BITS && cnt_r < WRITE_REG_BITS) begin
      byte1_r <= {byte1_r[6:0], si_i};
    end
  end

  always_ff @(posedge sck_i) begin
    if (cnt_r >= ADDR_END_BITS && cnt_r < WRITE_ANY_BITS) begin
      byte4_r <= {byte4_r[6:0], si_i};
    end
  end

  // ****************
  // status snapshot crossing
  // ****************
  // status_o moves at most once per core cycle, slower than the link
  // clock, so two equal samples in a row are a settled word; a
  // handshake would stall with the link clock stopped between frames
  always_ff @(posedge sck_i or posedge reset_i) begin
    if (reset_i) begin
      w1_r <= STATUS_RESET;
      w2_r <= STATUS_RESET;
      w3_r <= STATUS_RESET;
      spi_stat_r <= STATUS_RESET;
    end else begin
      w1_r <= status_o;
      w2_r <= w1_r;
      w3_r <= w2_r;
      if (w2_r == w3_r) begin
        spi_stat_r <= w3_r;
      end
    end
  end

  // ****************
  // status read out
  // ****************
  always_comb begin
    rd_active = 1'b0;
    rd_byte = spi_stat_r;
    if (op_r == READ_STATUS_ONE_CMD) begin
      rd_active = cnt_r >= OPCODE_BITS;
    end else if (op_r == READ_ANY_REGISTER_CMD) begin
      rd_active = cnt_r >= ADDR_END_BITS;
      if (addr_r != STATUS_ONE_VOLATILE_ADDR) begin
        rd_byte = STATUS_RESET;
      end
    end
  end

  assign rd_load = rd_active && (cnt_r[2:0] == 3'h0);
  assign so_oe_o = !cs_n_i && rd_active;

  fsr_shout u_shout (
    .clk_i(sck_i),
    .clear_i(cs_n_i),
    .load_i(rd_load),
    .byte_i(rd_byte),
    .bit_o(so_o)
  );

  // ****************
  // frame end and decode
  // ****************
  logic cs_s;
  logic cs_q_r;
  logic wp_s;
  logic dec_v_r;
  logic [7:0] dec_op_r;
  logic [5:0] dec_len_r;
  logic [23:0] dec_addr_r;
  logic [7:0] dec_data_r;

  fsr_sync #(
    .INIT(1'b1)
  ) u_cs_sync (
    .clk_i(clock_i),
    .rst_i(reset_i),
    .d_i(cs_n_i),
    .q_o(cs_s)
  );

  fsr_sync #(
    .INIT(1'b1)
  ) u_wp_sync (
    .clk_i(clock_i),
    .rst_i(reset_i),
    .d_i(wp_n_i),
    .q_o(wp_s)
  );

  // link registers are quiet once select is high; sample them then
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cs_q_r <= 1'b1;
      dec_v_r <= 1'b0;
    end else begin
      cs_q_r <= cs_s;
      dec_v_r <= cs_s && !cs_q_r;
    end
  end

  always_ff @(posedge clock_i) begin
    if (cs_s && !cs_q_r) begin
      dec_op_r <= op_r;
      dec_len_r <= len_r;
      dec_addr_r <= addr_r;
      if (op_r == WRITE_ANY_REGISTER_CMD) begin
        dec_data_r <= byte4_r;
      end else begin
        dec_data_r <= byte1_r;
      end
    end
  end

  // ****************
  // command qualification
  // ****************
  fsr_eng_t eng_r;
  fsr_kind_t kind_r;
  logic perr_r;
  logic eerr_r;
  logic wel_r;
  logic lock_r;
  logic [2:0] prot_v_r;
  logic busy;
  logic locked;
  logic wr_reg;
  logic do_wen;
  logic do_wdis;
  logic do_clr;
  logic do_srst;
  logic do_reg;
  logic do_prog;
  logic do_serase;
  logic do_berase;
  logic do_susp;
  logic is_erase;

  assign busy = (eng_r == FSR_ENG_RUN) || perr_r || eerr_r;
  assign locked = nv_status_i[LOCK_BIT] && !wp_s;
  assign is_erase = kind_r == FSR_KIND_SERASE ||
                    kind_r == FSR_KIND_BERASE;
  assign active_prot_o = prot_volatile_sel_i ? prot_v_r :
                         nv_status_i[PROT_TOP:PROT_BOT];

  always_comb begin
    wr_reg = 1'b0;
    if (dec_op_r == WRITE_REGISTERS_CMD) begin
      wr_reg = dec_len_r >= WRITE_REG_BITS;
    end else if (dec_op_r == WRITE_ANY_REGISTER_CMD) begin
      wr_reg = dec_len_r >= WRITE_ANY_BITS &&
               (dec_addr_r == STATUS_ONE_VOLATILE_ADDR ||
                dec_addr_r == STATUS_ONE_NONVOLATILE_ADDR);
    end
  end

  // busy leaves only clear status, reset and suspends live
  always_comb begin
    do_wen = 1'b0;
    do_wdis = 1'b0;
    do_clr = 1'b0;
    do_srst = 1'b0;
    do_reg = 1'b0;
    do_prog = 1'b0;
    do_serase = 1'b0;
    do_berase = 1'b0;
    do_susp = 1'b0;
    if (dec_v_r) begin
      case (dec_op_r)
        WRITE_ENABLE_CMD: begin
          do_wen = !busy;
        end
        WRITE_DISABLE_CMD: begin
          do_wdis = !busy;
        end
        CLEAR_STATUS_CMD, CLEAR_STATUS_ALT_CMD: begin
          do_clr = 1'b1;
        end
        SOFT_RESET_CMD: begin
          do_srst = 1'b1;
        end
        PAGE_PROGRAM_CMD, OTP_PROGRAM_CMD: begin
          do_prog = !busy && wel_r &&
                    dec_len_r >= ADDR_END_BITS;
        end
        SECTOR_ERASE_CMD: begin
          do_serase = !busy && wel_r &&
                      dec_len_r >= ADDR_END_BITS;
        end
        BULK_ERASE_CMD: begin
          do_berase = !busy && wel_r;
        end
        ERASE_SUSPEND_CMD: begin
          do_susp = eng_r == FSR_ENG_RUN && is_erase;
        end
        PROGRAM_SUSPEND_CMD: begin
          do_susp = eng_r == FSR_ENG_RUN &&
                    kind_r == FSR_KIND_PROG;
        end
        default: begin
          do_reg = wr_reg && !busy && wel_r && !locked;
        end
      endcase
    end
  end

  // ****************
  // array engine tracking
  // ****************
  logic start;
  fsr_kind_t start_kind;

  always_comb begin
    start = 1'b0;
    start_kind = FSR_KIND_PROG;
    if (do_prog && !protect_hit_i) begin
      start = 1'b1;
    end else if (do_serase && !protect_hit_i) begin
      start = 1'b1;
      start_kind = FSR_KIND_SERASE;
    end else if (do_berase && active_prot_o == 3'h0) begin
      start = 1'b1;
      start_kind = FSR_KIND_BERASE;
    end else if (do_reg && !prot_volatile_sel_i) begin
      start = 1'b1;
      start_kind = FSR_KIND_NVWR;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i || do_srst) begin
      eng_r <= FSR_ENG_IDLE;
      kind_r <= FSR_KIND_PROG;
    end else if (start) begin
      eng_r <= FSR_ENG_RUN;
      kind_r <= start_kind;
    end else if (eng_r == FSR_ENG_RUN &&
                 (op_done_i || prog_fail_i || erase_fail_i ||
                  op_suspended_i)) begin
      eng_r <= FSR_ENG_IDLE;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      op_start_o <= 1'b0;
      op_kind_o <= FSR_KIND_PROG;
      op_addr_o <= STATUS_ONE_NONVOLATILE_ADDR;
      nv_wdata_o <= STATUS_RESET;
      op_suspend_o <= 1'b0;
      soft_reset_o <= 1'b0;
    end else begin
      op_start_o <= start;
      op_suspend_o <= do_susp;
      soft_reset_o <= do_srst;
      if (start) begin
        op_kind_o <= start_kind;
        op_addr_o <= dec_addr_r;
        nv_wdata_o <= dec_data_r;
      end
    end
  end

  // ****************
  // status bits
  // ****************
  logic perr_set;
  logic eerr_set;
  logic done_ok;

  assign done_ok = eng_r == FSR_ENG_RUN && op_done_i;
  // protected attempts fail at once; bulk erase refusal is silent
  assign perr_set = (eng_r == FSR_ENG_RUN && prog_fail_i) ||
                    (do_prog && protect_hit_i);
  assign eerr_set = (eng_r == FSR_ENG_RUN && erase_fail_i) ||
                    (do_serase && protect_hit_i);

  // a failure landing with clear status is kept: set wins
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      perr_r <= 1'b0;
    end else if (perr_set) begin
      perr_r <= 1'b1;
    end else if (do_clr || do_srst) begin
      perr_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      eerr_r <= 1'b0;
    end else if (eerr_set) begin
      eerr_r <= 1'b1;
    end else if (do_clr || do_srst) begin
      eerr_r <= 1'b0;
    end
  end

  // write data never reaches the latch
  always_ff @(posedge clock_i) begin
    if (reset_i || do_srst) begin
      wel_r <= 1'b0;
    end else if (do_wen) begin
      wel_r <= 1'b1;
    end else if (do_wdis) begin
      wel_r <= 1'b0;
    end else if (done_ok || (do_reg && prot_volatile_sel_i)) begin
      wel_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    lock_r <= nv_status_i[LOCK_BIT];
  end

  // in stored mode the copy tracks the store, which the write updates
  always_ff @(posedge clock_i) begin
    if (reset_i || !prot_volatile_sel_i) begin
      prot_v_r <= nv_status_i[PROT_TOP:PROT_BOT];
    end else if (do_reg) begin
      prot_v_r <= dec_data_r[PROT_TOP:PROT_BOT];
    end
  end

  logic [7:0] status_now;

  always_comb begin
    status_now = STATUS_RESET;
    status_now[LOCK_BIT] = lock_r;
    status_now[PERR_BIT] = perr_r;
    status_now[EERR_BIT] = eerr_r;
    status_now[PROT_TOP:PROT_BOT] = prot_v_r;
    status_now[LATCH_BIT] = wel_r;
    status_now[BUSY_BIT] = busy;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      status_o <= STATUS_RESET;
    end else begin
      status_o <= status_now;
    end
  end

endmodule

// ### sim/fsr_asserts.sv
`timescale 1ns/1ps
// ****************
// status register checks
// ****************
module fsr_asserts
  import fsr_pkg::*;
(
  // system
  input wire logic clock_i,
  input wire logic reset_i,
  // pins and configuration
  input wire logic wp_n_i,
  input wire logic [7:0] nv_status_i,
  input wire logic prot_volatile_sel_i,
  // engine side
  input wire logic op_start_o,
  input wire fsr_kind_t op_kind_o,
  input wire logic op_suspend_o,
  input wire logic op_done_i,
  // status view
  input wire logic [7:0] status_o,
  input wire logic [2:0] active_prot_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  property p_start_gate;
    op_start_o |-> status_o[LATCH_BIT] && !status_o[BUSY_BIT];
  endproperty
  a_start_gate: assert property (p_start_gate)
    else $error("start without latch or while busy");
  property p_flag_busy;
    status_o[PERR_BIT] || status_o[EERR_BIT] |-> status_o[BUSY_BIT];
  endproperty
  a_flag_busy: assert property (p_flag_busy)
    else $error("failure flag set but not busy");
  // mirror may lag two cycles, so the stored bit must settle first
  property p_lock_mirror;
    $stable(nv_status_i[LOCK_BIT]) [*3]
      |-> status_o[LOCK_BIT] == nv_status_i[LOCK_BIT];
  endproperty
  a_lock_mirror: assert property (p_lock_mirror)
    else $error("lock copy differs from stored bit");
  property p_prot_nv;
    (!prot_volatile_sel_i && $stable(nv_status_i)) [*3]
      |-> active_prot_o == nv_status_i[PROT_TOP:PROT_BOT];
  endproperty
  a_prot_nv: assert property (p_prot_nv)
    else $error("stored protection not governing");
  property p_berase_clear;
    op_start_o && op_kind_o == FSR_KIND_BERASE |-> $past(active_prot_o) == 3'h0;
  endproperty
  a_berase_clear: assert property (p_berase_clear)
    else $error("bulk erase started with protection set");
  property p_latch_done;
    op_done_i |-> ##[2:3] !status_o[LATCH_BIT];
  endproperty
  a_latch_done: assert property (p_latch_done)
    else $error("latch kept after success");
  property p_susp_busy;
    op_suspend_o |-> status_o[BUSY_BIT] && !op_start_o;
  endproperty
  a_susp_busy: assert property (p_susp_busy)
    else $error("suspend while idle");
  property p_wlock;
    op_start_o && op_kind_o == FSR_KIND_NVWR |-> !(nv_status_i[LOCK_BIT] && !wp_n_i);
  endproperty
  a_wlock: assert property (p_wlock)
    else $error("register write while locked");
endmodule
bind fsr_status_one fsr_asserts fsr_asserts_inst (
  .clock_i(clock_i), .reset_i(reset_i), .wp_n_i(wp_n_i),
  .nv_status_i(nv_status_i), .prot_volatile_sel_i(prot_volatile_sel_i),
  .op_start_o(op_start_o), .op_kind_o(op_kind_o),
  .op_suspend_o(op_suspend_o), .op_done_i(op_done_i),
  .status_o(status_o), .active_prot_o(active_prot_o)
);

// ### sim/fsr_host.sv
`timescale 1ns/1ps
// ****************
// spi host, mode 0, 64 ns clock only inside frames
// ****************
module fsr_host (
  // link
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  task automatic frame(input logic [47:0] bits, input int n,
    output logic [7:0] rd);
    rd = 8'h00;
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      si_o = bits[47 - i];
      #32 sck_o = 1'b1;
      rd = {rd[6:0], so_i};
      #32 sck_o = 1'b0;
    end
    #32 cs_n_o = 1'b1;
    // released line must not keep showing the last bit
    si_o = ~si_o;
  endtask
endmodule

// ### sim/flash_status_register_one_bench.sv
`timescale 1ns/1ps
module flash_status_register_one_bench;
  import fsr_pkg::*;
  // ****************
  // signals and expected state
  // ****************
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic sck, cs_n, si, so, so_oe, start, sus_o, srst_o;
  logic wp_n = 1'b1, sel = 1'b0, hit = 1'b0, susp = 1'b0;
  logic done = 1'b0, pf = 1'b0, ef = 1'b0;
  logic write_enable_latch = 1'b0, pe = 1'b0, ee = 1'b0, bsy = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [2:0] aprot, pv = 3'h0;
  logic [7:0] nv = 8'h00, rd, d, wdat, st;
  logic [23:0] addr;
  logic [31:0] seed = 32'h0000_d102;
  fsr_kind_t kind;
  int n_fail = 0, n_compared = 0, n_start = 0, n_susp = 0, n_srst = 0, n0;
  fsr_status_one fsr_status_one_inst (
    .clock_i(clock_i), .reset_i(reset_i), .sck_i(sck), .cs_n_i(cs_n),
    .si_i(si), .so_o(so), .so_oe_o(so_oe), .wp_n_i(wp_n),
    .nv_status_i(nv), .prot_volatile_sel_i(sel), .op_start_o(start),
    .op_kind_o(kind), .op_addr_o(addr), .nv_wdata_o(wdat),
    .op_suspend_o(sus_o), .soft_reset_o(srst_o), .op_done_i(done),
    .prog_fail_i(pf), .erase_fail_i(ef), .op_suspended_i(susp),
    .protect_hit_i(hit), .status_o(st), .active_prot_o(aprot)
  );
  fsr_host fsr_host_inst (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so));
  always #50 clock_i = ~clock_i;
  always @(negedge clock_i) begin
    susp <= (sus_o === 1'b1);
    n_susp += (sus_o === 1'b1);
    n_srst += (srst_o === 1'b1);
  end
  // engine stand-in: answers five cycles after start, mode 3 never ends
  always @(negedge clock_i) begin
    if (start === 1'b1) begin
      n_start++;
      if (mode != 2'h3) begin
        repeat (5) @(negedge clock_i);
        done <= (mode == 2'h0);
        pf <= (mode == 2'h1);
        ef <= (mode == 2'h2);
        if (mode == 2'h0 && kind == FSR_KIND_NVWR) begin
          nv <= wdat & 8'h9c;
        end
        @(negedge clock_i);
        {done, pf, ef} <= 3'h0;
      end
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] est();
    return {nv[LOCK_BIT], pe, ee, sel ? pv : nv[4:2], write_enable_latch, bsy | pe | ee};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op, input int n,
    input logic [31:0] arg);
    fsr_host_inst.frame({op, arg, 8'h00}, n, rd);
    #2500;
    @(negedge clock_i);
  endtask
  task automatic wen();
    cmd(WRITE_ENABLE_CMD, 8, 32'h0);
    write_enable_latch = 1'b1;
  endtask
  task automatic look();
    cmd(READ_STATUS_ONE_CMD, 16, 32'h0);
    chk(rd, est());
    chk(st, est());
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (2) @(negedge clock_i);
    reset_i = 1'b0;
    repeat (4) @(negedge clock_i);
    look();
    wen();
    cmd(READ_ANY_REGISTER_CMD, 40, {STATUS_ONE_VOLATILE_ADDR, 8'h00});
    chk(rd, est());
    cmd(WRITE_DISABLE_CMD, 8, 32'h0);
    write_enable_latch = 1'b0;
    look();
    $display("latch test done");
    sel = 1'b1;
    n0 = n_start;
    for (int i = 0; i < 5; i++) begin
      // last write leaves every protection bit set for the next step
      d = (i == 4) ? 8'hff : rnd();
      wen();
      if (i[0]) cmd(WRITE_ANY_REGISTER_CMD, 40, {STATUS_ONE_VOLATILE_ADDR, d});
      else cmd(WRITE_REGISTERS_CMD, 16, {d, 24'h0});
      pv = d[4:2];
      write_enable_latch = 1'b0;
      look();
      chk({5'h0, aprot}, {5'h0, pv});
    end
    wen();
    cmd(BULK_ERASE_CMD, 8, 32'h0);
    look();
    chk(8'(n_start), 8'(n0));
    cmd(WRITE_REGISTERS_CMD, 16, 32'h0);
    pv = 3'h0;
    write_enable_latch = 1'b0;
    wen();
    cmd(BULK_ERASE_CMD, 8, 32'h0);
    chk({6'h0, kind}, {6'h0, FSR_KIND_BERASE});
    write_enable_latch = 1'b0;
    look();
    $display("volatile protection test done");
    sel = 1'b0;
    d = rnd();
    wen();
    cmd(WRITE_REGISTERS_CMD, 16, {d, 24'h0});
    chk(wdat, d);
    write_enable_latch = 1'b0;
    look();
    nv = 8'h80;
    wp_n = 1'b0;
    n0 = n_start;
    wen();
    cmd(WRITE_REGISTERS_CMD, 16, 32'h0);
    cmd(WRITE_ANY_REGISTER_CMD, 40, {STATUS_ONE_VOLATILE_ADDR, 8'h00});
    look();
    wp_n = 1'b1;
    #1000;
    cmd(WRITE_REGISTERS_CMD, 16, {8'h80, 24'h0});
    chk(8'(n_start), 8'(n0 + 1));
    nv = 8'h00;
    write_enable_latch = 1'b0;
    look();
    cmd(PAGE_PROGRAM_CMD, 32, rnd());
    chk(8'(n_start), 8'(n0 + 1));
    $display("stored protection test done");
    // failed and protected program and erase, cleared by either opcode
    for (int k = 0; k < 4; k++) begin
      mode = k[0] ? 2'h2 : 2'h1;
      hit = k[1];
      n0 = n_start;
      wen();
      cmd(k[0] ? SECTOR_ERASE_CMD : PAGE_PROGRAM_CMD, 32, rnd());
      chk(8'(n_start), 8'(n0 + 1 - k[1]));
      pe = !k[0];
      ee = k[0];
      look();
      cmd(WRITE_DISABLE_CMD, 8, 32'h0);
      cmd(WRITE_REGISTERS_CMD, 16, 32'h0);
      look();
      cmd(k[0] ? CLEAR_STATUS_ALT_CMD : CLEAR_STATUS_CMD, 8, 32'h0);
      {pe, ee} = 2'h0;
      look();
      cmd(WRITE_DISABLE_CMD, 8, 32'h0);
      write_enable_latch = 1'b0;
      look();
    end
    hit = 1'b0;
    $display("failure test done");
    mode = 2'h3;
    wen();
    n0 = n_susp;
    cmd(PAGE_PROGRAM_CMD, 32, 32'h0000_0100);
    bsy = 1'b1;
    look();
    cmd(ERASE_SUSPEND_CMD, 8, 32'h0);
    chk(8'(n_susp), 8'(n0));
    cmd(PROGRAM_SUSPEND_CMD, 8, 32'h0);
    chk(8'(n_susp), 8'(n0 + 1));
    bsy = 1'b0;
    chk({7'h0, st[BUSY_BIT]}, 8'h00);
    n0 = n_srst;
    cmd(SOFT_RESET_CMD, 8, 32'h0);
    chk(8'(n_srst), 8'(n0 + 1));
    write_enable_latch = 1'b0;
    look();
    $display("suspend and reset test done");
    give_verdict();
  end
endmodule
